/* peg_guard.sv */
// Purpose: position error counter with overflow and servo-on protection
// Assumes: deltas, power and mode come from logic on clk_i
// Notes:   settings are reset to their factory values by rst_i
`timescale 1ns/1ps
module peg_guard (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        pos_mode_i,
  input  wire logic                        servo_on_i,
  input  wire logic                        ref_valid_i,
  input  wire logic [peg_pkg::DELTA_W-1:0] ref_delta_i,
  input  wire logic [peg_pkg::DELTA_W-1:0] fb_delta_i,
  input  wire logic [peg_pkg::SPD_W-1:0]   speed_cmd_i,
  input  wire logic                        alarm_clear_i,
  input  wire logic                        excess_level_wr_i,
  input  wire logic                        son_level_wr_i,
  input  wire logic                        son_limit_wr_i,
  input  wire logic [peg_pkg::LVL_W-1:0]   level_data_i,
  input  wire logic [peg_pkg::LIM_W-1:0]   limit_data_i,
  input  wire logic [peg_pkg::GAIN_W-1:0]  loop_gain_i,
  input  wire logic [peg_pkg::GAIN_W-1:0]  model_following_gain_i,
  input  wire logic                        model_following_select_i,
  output logic      [peg_pkg::POS_W-1:0]   pos_error_o,
  output logic      [peg_pkg::SPD_W-1:0]   speed_cmd_o,
  output logic      [peg_pkg::GAIN_W-1:0]  active_gain_o,
  output logic                             speed_clamp_o,
  output logic                             motor_stop_o,
  output logic                             error_overflow_alarm_o,
  output logic                             servo_on_overflow_alarm_o,
  output logic                             speed_limited_overflow_alarm_o
);
  localparam int unsigned PW = peg_pkg::POS_W;
  localparam int unsigned SW = peg_pkg::SPD_W;

  logic [peg_pkg::LVL_W-1:0] excess_error_level;
  logic [peg_pkg::LVL_W-1:0] servo_on_error_level;
  logic [peg_pkg::LIM_W-1:0] servo_on_speed_limit;

  peg_setting #(.W(peg_pkg::LVL_W), .DEF(peg_pkg::LVL_DEFAULT),
    .MIN(peg_pkg::LVL_MIN), .MAX(peg_pkg::LVL_MAX)) u_excess (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (excess_level_wr_i),
    .data_i  (level_data_i),
    .value_o (excess_error_level)
  );
  peg_setting #(.W(peg_pkg::LVL_W), .DEF(peg_pkg::LVL_DEFAULT),
    .MIN(peg_pkg::LVL_MIN), .MAX(peg_pkg::LVL_MAX)) u_son_level (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (son_level_wr_i),
    .data_i  (level_data_i),
    .value_o (servo_on_error_level)
  );
  peg_setting #(.W(peg_pkg::LIM_W), .DEF(peg_pkg::LIM_DEFAULT),
    .MIN(peg_pkg::LIM_MIN), .MAX(peg_pkg::LIM_MAX)) u_son_limit (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (son_limit_wr_i),
    .data_i  (limit_data_i),
    .value_o (servo_on_speed_limit)
  );

  // error counter
  logic [PW-1:0] err_q;
  logic [PW-1:0] err_d;
  logic [PW-1:0] ref_ext;
  logic [PW-1:0] fb_ext;
  logic [PW-1:0] err_abs;
  logic          over_excess;
  logic          over_son;

  assign ref_ext = ref_valid_i ?
    {{(PW-peg_pkg::DELTA_W){ref_delta_i[peg_pkg::DELTA_W-1]}}, ref_delta_i}
    : '0;
  assign fb_ext =
    {{(PW-peg_pkg::DELTA_W){fb_delta_i[peg_pkg::DELTA_W-1]}}, fb_delta_i};
  assign err_abs = err_q[PW-1] ? PW'(-err_q) : err_q;
  assign over_excess = err_abs > {2'h0, excess_error_level};
  assign over_son    = err_abs > {2'h0, servo_on_error_level};

  // counter keeps running through power off so nothing is lost
  always_comb begin
    err_d = PW'(err_q + ref_ext - fb_ext);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  // guard state and alarms
  peg_pkg::peg_state_t state_q;
  peg_pkg::peg_state_t state_d;
  logic                power_q;
  logic                ovf_q;
  logic                ovf_d;
  logic                son_q;
  logic                son_d;
  logic                slim_q;
  logic                slim_d;
  logic                power_rise;

  assign power_rise = servo_on_i && !power_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      peg_pkg::PEG_OFF: begin
        if (power_rise) begin
          state_d = (err_q != '0) ? peg_pkg::PEG_CLAMP : peg_pkg::PEG_RUN;
        end
      end
      peg_pkg::PEG_CLAMP: begin
        if (!servo_on_i) begin
          state_d = peg_pkg::PEG_OFF;
        end else if (err_q == '0) begin
          state_d = peg_pkg::PEG_RUN;
        end
      end
      peg_pkg::PEG_RUN: begin
        if (!servo_on_i) begin
          state_d = peg_pkg::PEG_OFF;
        end
      end
      default: begin
        state_d = peg_pkg::PEG_OFF;
      end
    endcase
  end

  // set beats clear; clear only once the error is back within level
  always_comb begin
    ovf_d  = ovf_q;
    son_d  = son_q;
    slim_d = slim_q;
    if (alarm_clear_i && !over_excess) begin
      ovf_d  = 1'b0;
      slim_d = 1'b0;
    end
    if (alarm_clear_i && !over_son) begin
      son_d = 1'b0;
    end
    if (pos_mode_i) begin
      if ((state_q == peg_pkg::PEG_RUN) && over_excess) begin
        ovf_d = 1'b1;
      end
      if ((state_q == peg_pkg::PEG_OFF) && power_rise && over_son) begin
        son_d = 1'b1;
      end
      if ((state_q == peg_pkg::PEG_CLAMP) && ref_valid_i && over_excess) begin
        slim_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= peg_pkg::PEG_OFF;
      power_q <= 1'b0;
      ovf_q   <= 1'b0;
      son_q   <= 1'b0;
      slim_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      power_q <= servo_on_i;
      ovf_q   <= ovf_d;
      son_q   <= son_d;
      slim_q  <= slim_d;
    end
  end

  // speed output and gain selection
  logic [SW-1:0]             spd_q;
  logic [SW-1:0]             spd_d;
  logic [peg_pkg::GAIN_W-1:0] gain_q;
  logic [peg_pkg::GAIN_W-1:0] gain_d;
  logic [SW-1:0]             lim_ext;
  logic [SW-1:0]             lim_neg;
  logic                      any_alarm_d;

  assign lim_ext = {{(SW-peg_pkg::LIM_W){1'b0}}, servo_on_speed_limit};
  assign lim_neg = SW'(-lim_ext);
  assign any_alarm_d = ovf_d || son_d || slim_d;

  // stop wins over clamp; clamp is a signed window of +/- limit
  always_comb begin
    spd_d = speed_cmd_i;
    if (any_alarm_d || (state_d == peg_pkg::PEG_OFF)) begin
      spd_d = '0;
    end else if (state_d == peg_pkg::PEG_CLAMP) begin
      if ($signed(speed_cmd_i) > $signed(lim_ext)) begin
        spd_d = lim_ext;
      end else if ($signed(speed_cmd_i) < $signed(lim_neg)) begin
        spd_d = lim_neg;
      end
    end
    // gains in units of 0.1/s, passed through untouched
    gain_d = model_following_select_i ? model_following_gain_i
                                      : loop_gain_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd_q  <= '0;
      gain_q <= '0;
    end else begin
      spd_q  <= spd_d;
      gain_q <= gain_d;
    end
  end

  assign pos_error_o                    = err_q;
  assign speed_cmd_o                    = spd_q;
  assign active_gain_o                  = gain_q;
  assign speed_clamp_o                  = (state_q == peg_pkg::PEG_CLAMP);
  assign motor_stop_o                   = ovf_q || son_q || slim_q;
  assign error_overflow_alarm_o         = ovf_q;
  assign servo_on_overflow_alarm_o      = son_q;
  assign speed_limited_overflow_alarm_o = slim_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence power_on_big_s;
    !servo_on_i ##1 servo_on_i && pos_mode_i && over_son;
  endsequence

  err_track_a: assert property (
    ##1 err_q == PW'($past(err_q) + $past(ref_ext) - $past(fb_ext)))
    else $error("error counter lost a delta");
  mode_gate_a: assert property (
    $rose(ovf_q) || $rose(son_q) || $rose(slim_q) |-> $past(pos_mode_i))
    else $error("alarm raised outside position control");
  ovf_set_a: assert property (
    state_q == peg_pkg::PEG_RUN && pos_mode_i && over_excess |=> ovf_q)
    else $error("overflow alarm missed");
  stop_hold_a: assert property (
    motor_stop_o |-> spd_q == '0)
    else $error("motor not stopped under alarm");
  lvl_write_a: assert property (
    excess_level_wr_i && level_data_i != '0 |=>
    excess_error_level == $past(level_data_i))
    else $error("excess level not taken at once");
  gain_sel_a: assert property (
    model_following_select_i |=> gain_q == $past(model_following_gain_i))
    else $error("wrong gain selected");
  retain_a: assert property (
    !servo_on_i && !ref_valid_i && fb_delta_i == '0 |=> $stable(err_q))
    else $error("error changed while idle with power off");
  son_alarm_a: assert property (
    power_on_big_s ##0 state_q == peg_pkg::PEG_OFF |=> son_q)
    else $error("servo-on alarm missed");
  // the window was applied with last cycle's limit, hence the past values
  clamp_lim_a: assert property (
    speed_clamp_o && !motor_stop_o |->
    ($signed(spd_q) <= $signed($past(lim_ext))) &&
    ($signed(spd_q) >= $signed($past(lim_neg))))
    else $error("speed outside servo-on limit");
  slim_set_a: assert property (
    speed_clamp_o && pos_mode_i && ref_valid_i && over_excess |=> slim_q)
    else $error("speed-limited alarm missed");
  alarm_latch_a: assert property (
    ovf_q && !alarm_clear_i |=> ovf_q [*1] ##0 motor_stop_o)
    else $error("alarm dropped without clear");
endmodule

/* peg_host.sv */
// Purpose: host motion controller model that issues position references
// Assumes: send is called just after a rising edge of clk_i
// Notes:   delta starts at zero, then is scrambled whenever send drops the reference valid
`timescale 1ns/1ps
module peg_host (
  input  wire logic                        clk_i,
  output logic                             ref_valid_o,
  output logic      [peg_pkg::DELTA_W-1:0] ref_delta_o
);
  initial begin
    ref_valid_o = 1'b0;
    ref_delta_o = 16'h0000;
  end

  // gap 0 streams back to back, a larger gap models a slow host
  task automatic send(input logic [peg_pkg::DELTA_W-1:0] d,
                      input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      ref_valid_o = 1'b1;
      ref_delta_o = d;
      @(posedge clk_i);
      #1;
      if (gap != 0 || i == n - 1) begin
        ref_valid_o = 1'b0;
        // stale data must never pass for a real increment
        ref_delta_o = ~d;
        repeat (gap) @(posedge clk_i);
        if (gap != 0) #1;
      end
    end
  endtask
endmodule

/* peg_pkg.sv */
// Purpose: shared constants for the position error guard
// Assumes: one drive control clock, positions in reference units
// Notes:   all settings are unsigned, the error counter is signed
package peg_pkg;
  localparam int unsigned POS_W   = 32;
  localparam int unsigned DELTA_W = 16;
  localparam int unsigned LVL_W   = 30;
  localparam int unsigned SPD_W   = 16;
  localparam int unsigned LIM_W   = 14;
  localparam int unsigned GAIN_W  = 16;

  // error levels in reference units
  localparam logic [LVL_W-1:0] LVL_MIN     = 30'h0000_0001;
  localparam logic [LVL_W-1:0] LVL_MAX     = 30'h3FFF_FFFF;
  localparam logic [LVL_W-1:0] LVL_DEFAULT = 30'h0050_0000;

  // servo-on speed limit in min^-1
  localparam logic [LIM_W-1:0] LIM_MIN     = 14'h0000;
  localparam logic [LIM_W-1:0] LIM_MAX     = 14'h2710;
  localparam logic [LIM_W-1:0] LIM_DEFAULT = 14'h2710;

  // one-hot guard states
  typedef enum logic [2:0] {
    PEG_OFF   = 3'b001,
    PEG_CLAMP = 3'b010,
    PEG_RUN   = 3'b100
  } peg_state_t;
endpackage

/* peg_setting.sv */
// Purpose: one setting register, range limited, loaded by a strobe
// Assumes: write strobe from logic on the same clock
// Notes:   out of range writes are pulled to the nearest limit
`timescale 1ns/1ps
module peg_setting #(
  parameter int unsigned     W   = 30,
  parameter logic [W-1:0]    DEF = '0,
  parameter logic [W-1:0]    MIN = '0,
  parameter logic [W-1:0]    MAX = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] value_o
);
  logic [W-1:0] value_q;
  logic [W-1:0] value_d;

  always_comb begin
    value_d = value_q;
    if (wr_i) begin
      if (data_i < MIN) begin
        value_d = MIN;
      end else if (data_i > MAX) begin
        value_d = MAX;
      end else begin
        value_d = data_i;
      end
    end
  end

  // the new level is in force on the edge after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_q <= DEF;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

  range_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (value_q >= MIN) && (value_q <= MAX))
    else $error("setting left its range");
endmodule

/* tb_peg_guard.sv */
// Purpose: self-checking bench for the position error guard
// Assumes: inputs change 1 ns after the rising edge
// Notes:   only fixed latencies are waited for, so no wait can hang
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_peg_guard;
  logic        clk_i = 1'b0, rst_i = 1'b1, pos_mode_i = 1'b0;
  logic        servo_on_i = 1'b0, alarm_clear_i = 1'b0, mf_sel_i = 1'b0;
  logic        excess_wr_i = 1'b0, son_wr_i = 1'b0, lim_wr_i = 1'b0;
  logic [15:0] fb_delta_i = '0, speed_cmd_i = '0, ref_delta_i;
  logic [15:0] loop_gain_i = '0, mf_gain_i = '0;
  logic [29:0] level_data_i = '0;
  logic [13:0] limit_data_i = '0;
  logic        ref_valid_i;
  logic [31:0] pos_error_o;
  logic [15:0] speed_cmd_o, active_gain_o;
  logic        speed_clamp_o, motor_stop_o, ovf_o, son_o, slim_o;
  int          failures = 0, checked = 0;

  always #5 clk_i = ~clk_i;

  peg_host host (.clk_i(clk_i), .ref_valid_o(ref_valid_i),
                 .ref_delta_o(ref_delta_i));

  peg_guard uut (
    .clk_i(clk_i), .rst_i(rst_i), .pos_mode_i(pos_mode_i),
    .servo_on_i(servo_on_i), .ref_valid_i(ref_valid_i),
    .ref_delta_i(ref_delta_i), .fb_delta_i(fb_delta_i),
    .speed_cmd_i(speed_cmd_i), .alarm_clear_i(alarm_clear_i),
    .excess_level_wr_i(excess_wr_i), .son_level_wr_i(son_wr_i),
    .son_limit_wr_i(lim_wr_i), .level_data_i(level_data_i),
    .limit_data_i(limit_data_i), .loop_gain_i(loop_gain_i),
    .model_following_gain_i(mf_gain_i),
    .model_following_select_i(mf_sel_i), .pos_error_o(pos_error_o),
    .speed_cmd_o(speed_cmd_o), .active_gain_o(active_gain_o),
    .speed_clamp_o(speed_clamp_o), .motor_stop_o(motor_stop_o),
    .error_overflow_alarm_o(ovf_o), .servo_on_overflow_alarm_o(son_o),
    .speed_limited_overflow_alarm_o(slim_o));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_level(input logic [29:0] v, input logic son);
    level_data_i = v;
    if (son) son_wr_i = 1'b1;
    else excess_wr_i = 1'b1;
    tick(1);
    son_wr_i = 1'b0;
    excess_wr_i = 1'b0;
  endtask

  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    tick(16);
    rst_i = 1'b0;
    `CHK(pos_error_o, 32'h0000_0000)
    loop_gain_i = 16'h0190;
    mf_gain_i = 16'h0028;
    tick(1);
    `CHK(active_gain_o, 16'h0190)
    mf_sel_i = 1'b1;
    tick(1);
    `CHK(active_gain_o, 16'h0028)
    // slow host while power is off: error must build and be kept
    host.send(16'h000A, 4, 1);
    fb_delta_i = 16'h0003;
    tick(2);
    fb_delta_i = 16'h0000;
    tick(3);
    `CHK(pos_error_o, 32'h0000_0022)
    limit_data_i = 14'h0005;
    lim_wr_i = 1'b1;
    tick(1);
    lim_wr_i = 1'b0;
    speed_cmd_i = 16'h0064;
    pos_mode_i = 1'b1;
    servo_on_i = 1'b1;
    tick(1);
    `CHK(speed_clamp_o, 1'b1)
    `CHK(speed_cmd_o, 16'h0005)
    `CHK(son_o, 1'b0)
    speed_cmd_i = 16'hFF9C;
    fb_delta_i = 16'h0011;
    tick(2);
    `CHK(speed_cmd_o, 16'hFFFB)
    speed_cmd_i = 16'h0064;
    fb_delta_i = 16'h0000;
    tick(2);
    `CHK(pos_error_o, 32'h0000_0000)
    `CHK(speed_clamp_o, 1'b0)
    `CHK(speed_cmd_o, 16'h0064)
    // climb exactly to the factory level, then one unit past it
    host.send(16'h7FFF, 160, 0);
    // let an edge pass so valid is not dropped and raised in one step
    tick(1);
    host.send(16'h00A0, 1, 0);
    tick(1);
    `CHK(pos_error_o, 32'h0050_0000)
    `CHK(ovf_o, 1'b0)
    host.send(16'h0001, 1, 0);
    tick(1);
    `CHK(ovf_o, 1'b1)
    `CHK(motor_stop_o, 1'b1)
    `CHK(speed_cmd_o, 16'h0000)
    alarm_clear_i = 1'b1;
    tick(2);
    `CHK(ovf_o, 1'b1)
    fb_delta_i = 16'h0002;
    tick(1);
    fb_delta_i = 16'h0000;
    tick(2);
    `CHK(ovf_o, 1'b0)
    alarm_clear_i = 1'b0;
    pos_mode_i = 1'b0;
    host.send(16'h0010, 1, 0);
    tick(2);
    `CHK(ovf_o, 1'b0)
    servo_on_i = 1'b0;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    `CHK(pos_error_o, 32'h0000_0000)
    servo_on_i = 1'b1;
    pos_mode_i = 1'b1;
    tick(2);
    // a zero level is pulled up to one and used at once
    wr_level(30'h0000_0000, 1'b0);
    host.send(16'h0001, 1, 0);
    tick(1);
    `CHK(ovf_o, 1'b0)
    host.send(16'h0001, 1, 0);
    tick(1);
    `CHK(ovf_o, 1'b1)
    fb_delta_i = 16'h0001;
    alarm_clear_i = 1'b1;
    tick(1);
    fb_delta_i = 16'h0000;
    tick(2);
    `CHK(ovf_o, 1'b0)
    alarm_clear_i = 1'b0;
    servo_on_i = 1'b0;
    tick(1);
    host.send(16'h0064, 1, 0);
    wr_level(30'h0000_0032, 1'b1);
    wr_level(30'h0000_00C8, 1'b0);
    servo_on_i = 1'b1;
    tick(1);
    `CHK(son_o, 1'b1)
    `CHK(speed_clamp_o, 1'b1)
    `CHK(speed_cmd_o, 16'h0000)
    alarm_clear_i = 1'b1;
    fb_delta_i = 16'h0033;
    tick(1);
    fb_delta_i = 16'h0000;
    tick(2);
    `CHK(son_o, 1'b0)
    alarm_clear_i = 1'b0;
    host.send(16'h00C8, 1, 0);
    tick(2);
    `CHK(slim_o, 1'b0)
    `CHK(ovf_o, 1'b0)
    host.send(16'h0001, 1, 0);
    tick(1);
    `CHK(slim_o, 1'b1)
    `CHK(speed_cmd_o, 16'h0000)
    end_sim;
  end
endmodule
